// [verilog/rpf_reset_pad.sv]
/*
  Reset pad logic with function select and reset release sequencer.
  The pad is either the hardware reset input or a port pin that reads the
  pad level and can only pull it low; the sequencer turns the merged reset
  sources into one internal reset, asserted at once and released in step with the clock, for the rest of the chip.
  Assumes pad inputs are synchronous-sampled, and that power-on, watchdog
  and software resets arrive as active-low levels. Assumes a pull-up on
  the pad, since nothing inside ever drives it high.
*/
`include "rpf_regs.svh"
module rpf_reset_pad
  import rpf_pkg::*;
#(
  parameter int NUM_PADS = `RPF_NUM_PADS,
  parameter int REL_CYC  = `RPF_RELEASE_CYCLES
) (
  input  wire logic                CLK_SYS,        // System clock.
  input  wire logic                RESET_N,        // Power-on reset, low.
  input  wire logic                WDOG_RST_N,     // Watchdog reset, low.
  input  wire logic                SW_RST_N,       // Software reset, low.
  input  wire logic                PAD_IN,         // Reset pad level.
  output logic                     PAD_OUT,        // Pad output value.
  output logic                     PAD_OE,         // Pad output enable.
  input  wire logic                CFG_WR,         // Config write strobe.
  input  wire logic [NUM_PADS-1:0] CFG_ALT,        // Alternate selects.
  input  wire logic                CFG_PORT_MODE,  // Reset pad as port.
  input  wire logic                PORT_DRIVE_LOW, // Port output pull low.
  output logic [NUM_PADS-1:0]      PAD_ALT_SEL,    // Active alternate set.
  output logic                     PAD_PORT_SEL,   // Pad is port_a_bit7_io.
  output logic                     PORT_A_BIT7_IO, // Port input value.
  output logic                     CHIP_RST_N      // Internal reset, low.
);
  logic                 sync1_ff;
  logic                 sync2_ff;
  logic                 port_sel_ff;
  logic [NUM_PADS-1:0]  alt_ff;
  logic                 oe_ff;
  logic                 in_ff;
  logic                 rst_out_ff;
  logic [`RPF_CNT_W-1:0] cnt_ff;
  rpf_state_t           state_ff;
  rpf_state_t           nxt_state;
  logic [`RPF_CNT_W-1:0] nxt_cnt;
  wire                  watchdog_reset_source;
  wire                  src_rst_n;
  wire                  pad_rst_n;
  wire                  cnt_done;
  wire                  seq_rst_n;
  localparam int        HI_W = `RPF_CNT_W + 1;
  logic [HI_W-1:0]      hi_run_ff;

  assign watchdog_reset_source = ~WDOG_RST_N;
  // The pad joins the reset tree only in reset mode; the mode flop resets
  // from sources other than the pad so port mode cannot reset itself.
  assign pad_rst_n = PAD_IN | port_sel_ff;
  assign src_rst_n = RESET_N & ~watchdog_reset_source & SW_RST_N;

  // A pad low in reset mode must clear the sequencer at once, so the
  // pad path joins the async clear of the sequencer too.
  assign seq_rst_n = src_rst_n & pad_rst_n;

  // Assertion is immediate through the async clear; release is aligned.
  // The synchroniser clears on the pad as well, otherwise a stale high
  // left in its second stage would let the sequencer start counting one
  // edge after a short pad pulse and then fall back to hold.
  always_ff @(posedge CLK_SYS or negedge seq_rst_n) begin
    if (!seq_rst_n) begin
      sync1_ff <= 1'h0;
      sync2_ff <= 1'h0;
    end else begin
      sync1_ff <= pad_rst_n;
      sync2_ff <= sync1_ff;
    end
  end

  assign cnt_done = (cnt_ff == `RPF_CNT_W'(REL_CYC - 1));

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      RPF_HOLD: begin
        nxt_cnt = '0;
        if (sync2_ff) nxt_state = RPF_COUNT;
      end
      RPF_COUNT: begin
        nxt_cnt = cnt_ff + `RPF_CNT_W'(1);
        if (!sync2_ff) nxt_state = RPF_HOLD;
        else if (cnt_done) nxt_state = RPF_RUN;
      end
      RPF_RUN: begin
        if (!sync2_ff) nxt_state = RPF_HOLD;
      end
      default: nxt_state = RPF_HOLD;
    endcase
  end

  // The release flop is a plain register of the next state, so the
  // internal reset output never glitches while the count runs.
  always_ff @(posedge CLK_SYS or negedge seq_rst_n) begin
    if (!seq_rst_n) begin
      state_ff   <= RPF_HOLD;
      cnt_ff     <= '0;
      rst_out_ff <= 1'h0;
    end else begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      rst_out_ff <= (nxt_state == RPF_RUN);
    end
  end

  // Configuration is only cleared asynchronously by sources other than the pad itself.
  // While the chip is held in reset through the pad in reset mode, the
  // selects are forced back to the primary functions every cycle and any
  // write is ignored; in port mode the pad cannot hold the chip, so
  // writes are taken as soon as they come.
  always_ff @(posedge CLK_SYS or negedge src_rst_n) begin
    if (!src_rst_n) begin
      port_sel_ff <= `RPF_SEL_PRIMARY;
      alt_ff      <= '0;
    end else if (!rst_out_ff && !port_sel_ff) begin
      port_sel_ff <= `RPF_SEL_PRIMARY;
      alt_ff      <= '0;
    end else if (CFG_WR) begin
      port_sel_ff <= CFG_PORT_MODE;
      alt_ff      <= CFG_ALT;
    end
  end

  // The pull-low enable and the port input are registered so that every
  // output but the constant PAD_OUT leaves from a flop; the enable lags the mode by one cycle.
  always_ff @(posedge CLK_SYS or negedge src_rst_n) begin
    if (!src_rst_n) begin
      oe_ff <= 1'h0;
      in_ff <= 1'h1;
    end else begin
      oe_ff <= port_sel_ff & PORT_DRIVE_LOW;
      in_ff <= PAD_IN;
    end
  end

  assign PAD_OUT        = 1'h0;
  assign PAD_OE         = oe_ff;
  assign PAD_ALT_SEL    = alt_ff;
  assign PAD_PORT_SEL   = port_sel_ff;
  assign PORT_A_BIT7_IO = in_ff;
  assign CHIP_RST_N     = rst_out_ff;

  // Cycles with the synchronised pad level high, counted apart from the
  // sequencer so that the release check does not lean on cnt_ff itself.
  // It saturates, so a long stay in RPF_RUN cannot wrap it back to a
  // value that would look like a fresh release.
  always_ff @(posedge CLK_SYS or negedge seq_rst_n) begin
    if (!seq_rst_n) begin
      hi_run_ff <= '0;
    end else if (!sync2_ff) begin
      hi_run_ff <= '0;
    end else if (hi_run_ff != '1) begin
      hi_run_ff <= hi_run_ff + HI_W'(1);
    end
  end

  // Release comes REL_CYC + 1 edges after the synchronised level first
  // reads high: one edge to leave RPF_HOLD, then REL_CYC counting edges.
  chk_release_exact: assert property (
    @(posedge CLK_SYS) disable iff (!seq_rst_n)
    $rose(CHIP_RST_N) |-> hi_run_ff == HI_W'(REL_CYC + 1))
    else $error("Reset released after the wrong count.");
  chk_run_drives_out: assert property (
    @(posedge CLK_SYS) disable iff (!seq_rst_n)
    (state_ff == RPF_RUN) == CHIP_RST_N)
    else $error("Release output out of step with sequencer.");
  chk_count_range: assert property (
    @(posedge CLK_SYS) disable iff (!seq_rst_n)
    state_ff == RPF_COUNT |-> cnt_ff < `RPF_CNT_W'(REL_CYC))
    else $error("Release counter overran.");
  chk_pad_resets: assert property (
    @(posedge CLK_SYS) disable iff (!src_rst_n)
    !PAD_PORT_SEL && !PAD_IN |-> !CHIP_RST_N)
    else $error("Low pad in reset mode did not reset.");
  chk_mode_no_oe: assert property (
    @(posedge CLK_SYS) disable iff (!src_rst_n)
    !CHIP_RST_N && !PAD_PORT_SEL |=> !PAD_OE)
    else $error("Pad pulled low while in reset mode.");
  chk_write_lands: assert property (
    @(posedge CLK_SYS) disable iff (!src_rst_n)
    CFG_WR && (CHIP_RST_N || PAD_PORT_SEL) |=>
      PAD_ALT_SEL == $past(CFG_ALT) &&
      PAD_PORT_SEL == $past(CFG_PORT_MODE))
    else $error("Configuration write not taken.");
  chk_alt_cleared: assert property (
    @(posedge CLK_SYS) disable iff (!src_rst_n)
    !CHIP_RST_N && !PAD_PORT_SEL |=> PAD_ALT_SEL == '0)
    else $error("Secondary function kept during reset.");
  chk_port_input: assert property (
    @(posedge CLK_SYS) disable iff (!src_rst_n)
    PAD_PORT_SEL |=> PORT_A_BIT7_IO == $past(PAD_IN))
    else $error("Port input does not follow the pad.");
  chk_port_no_high: assert property (
    @(posedge CLK_SYS) disable iff (!src_rst_n)
    PAD_OE |-> PAD_OUT == 1'h0) else $error("Pad driven high.");
  chk_oe_only_port: assert property (
    @(posedge CLK_SYS) disable iff (!src_rst_n)
    PAD_OE |-> $past(port_sel_ff)) else $error("Pad driven in reset mode.");
  chk_cfg_needs_write: assert property (
    @(posedge CLK_SYS) disable iff (!src_rst_n)
    $changed(PAD_ALT_SEL) && CHIP_RST_N |-> $past(CFG_WR))
    else $error("Alternate changed without write.");
  chk_port_no_reset: assert property (
    @(posedge CLK_SYS) disable iff (!src_rst_n)
    PAD_PORT_SEL && CHIP_RST_N |=> CHIP_RST_N)
    else $error("Port mode pad reset the chip.");
  chk_hold_in_reset: assert property (
    @(posedge CLK_SYS) disable iff (!src_rst_n)
    !sync2_ff |=> !CHIP_RST_N) else $error("Reset not held.");
  chk_primary_after: assert property (
    @(posedge CLK_SYS) disable iff (!src_rst_n)
    $rose(CHIP_RST_N) && !$past(PAD_PORT_SEL) |-> PAD_ALT_SEL == '0)
    else $error("Secondary function active at release.");
  chk_sync_two_stage: assert property (
    @(posedge CLK_SYS) disable iff (!seq_rst_n)
    $rose(sync1_ff) |=> sync2_ff) else $error("Synchroniser depth wrong.");
endmodule

// [verilog/rpf_regs.svh]
/*
  Constants of the reset pad and pad function select block.
  Assumes inclusion by the rpf top module only; the rpf package does not include it.
*/
`ifndef RPF_REGS_SVH
`define RPF_REGS_SVH
`define RPF_RELEASE_CYCLES 16
`define RPF_CNT_W          5
`define RPF_SEL_PRIMARY    1'h0
`define RPF_SEL_PORT       1'h1
`define RPF_NUM_PADS       8
`endif

// [verilog/rpf_pkg.sv]
/*
  Types of the reset pad and pad function select block.
  Assumes the constants header is compiled alongside.
*/
package rpf_pkg;
  typedef enum logic [1:0] {
    RPF_HOLD    = 2'h0,
    RPF_COUNT   = 2'h1,
    RPF_RUN     = 2'h2
  } rpf_state_t;
endpackage

// [dv/rpf_pad_model.sv]
/*
  Board side of the reset pad: a reset source and the pad pull-up.
  Assumes the device only ever pulls the pad low through PAD_OE.
*/
module rpf_pad_model (
  input  wire logic BOARD_LOW, // Board source holds pad low.
  input  wire logic PAD_OE,    // Device pulls pad low.
  input  wire logic PAD_OUT,   // Device output value.
  output logic      PAD_LVL    // Resolved pad level.
);
  timeunit 1ns;
  timeprecision 1ns;
  // Only low drivers exist, so the pull-up wins otherwise.
  assign PAD_LVL = (BOARD_LOW || (PAD_OE && !PAD_OUT)) ? 1'b0 : 1'b1;
endmodule

// [dv/test_rpf_reset_pad.sv]
/*
  Self-checking bench of the reset pad and pad function select block.
  Assumes a 50 MHz clock and a release count shortened to four.
*/
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
  bad_count++; $display("Error %s exp %h got %h", n, e, s); end end
module test_rpf_reset_pad;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int REL = 4;
  logic       clk_sys = 1'b0;
  logic [2:0] src_n = 3'h6;
  logic       board_low = 1'b0, cfg_wr = 1'b0, mode = 1'b0, drv = 1'b0;
  logic [7:0] cfg_alt = 8'h00, alt_v, alt_sel;
  logic       pad_in, pad_out, pad_oe, port_sel, port_in, chip_n;
  int         bad_count = 0, check_count = 0;
  always #10 clk_sys = ~clk_sys;
  rpf_pad_model rpf_pad_model_i (.BOARD_LOW(board_low), .PAD_OE(pad_oe),
    .PAD_OUT(pad_out), .PAD_LVL(pad_in));
  rpf_reset_pad #(.NUM_PADS(8), .REL_CYC(REL)) rpf_reset_pad_i (
    .CLK_SYS(clk_sys), .RESET_N(src_n[0]), .WDOG_RST_N(src_n[1]),
    .SW_RST_N(src_n[2]), .PAD_IN(pad_in), .PAD_OUT(pad_out),
    .PAD_OE(pad_oe), .CFG_WR(cfg_wr), .CFG_ALT(cfg_alt),
    .CFG_PORT_MODE(mode), .PORT_DRIVE_LOW(drv), .PAD_ALT_SEL(alt_sel),
    .PAD_PORT_SEL(port_sel), .PORT_A_BIT7_IO(port_in), .CHIP_RST_N(chip_n));
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task release_chk;
    // Two synchroniser edges, one to leave hold, then REL counting edges.
    tick(REL + 2);
    `CHK("chip_early", 1'b0, chip_n)
    tick(1);
    `CHK("chip_rel", 1'b1, chip_n)
    `CHK("alt_dflt", 8'h00, alt_sel)
    `CHK("port_dflt", 1'b0, port_sel)
  endtask
  task cfg(input logic [7:0] a, input logic p);
    @(posedge clk_sys) begin
      cfg_wr <= 1'b1;
      cfg_alt <= a;
      mode <= p;
    end
    @(posedge clk_sys) cfg_wr <= 1'b0;
    tick(1);
    `CHK("alt_sel", a, alt_sel)
    `CHK("port_sel", p, port_sel)
  endtask
  task final_report;
    if (bad_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h9413));
    tick(4);
    `CHK("chip_por", 1'b0, chip_n)
    @(posedge clk_sys) src_n <= 3'h7;
    release_chk();
    repeat (6) begin
      alt_v = 8'($urandom);
      cfg(alt_v, 1'b0);
      tick(3);
      `CHK("alt_hold", alt_v, alt_sel)
    end
    // A low pad in reset mode is a full chip reset, taken at once.
    @(posedge clk_sys) board_low <= 1'b1;
    #1 `CHK("chip_pad", 1'b0, chip_n)
    @(posedge clk_sys) board_low <= 1'b0;
    release_chk();
    cfg(8'h5A, 1'b1);
    @(posedge clk_sys) drv <= 1'b1;
    tick(3);
    `CHK("oe_low", 1'b1, pad_oe)
    `CHK("out_low", 1'b0, pad_out)
    `CHK("chip_od", 1'b1, chip_n)
    @(posedge clk_sys) begin
      drv <= 1'b0;
      board_low <= 1'b1;
    end
    tick(3);
    `CHK("oe_off", 1'b0, pad_oe)
    `CHK("port_in0", 1'b0, port_in)
    `CHK("chip_port", 1'b1, chip_n)
    @(posedge clk_sys) board_low <= 1'b0;
    tick(3);
    `CHK("port_in1", 1'b1, port_in)
    // Each remaining source still resets the chip in port mode.
    for (int i = 0; i < 3; i++) begin
      cfg(8'hA5, 1'b1);
      @(posedge clk_sys) src_n <= ~(3'h1 << i);
      tick(2);
      `CHK("chip_src", 1'b0, chip_n)
      @(posedge clk_sys) src_n <= 3'h7;
      release_chk();
    end
    final_report();
  end
  initial begin
    #100000;
    bad_count++;
    final_report();
  end
endmodule
